// ### hdl/sbat_cfg.svh
// Constants for the segment and block address translation front end.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SBAT_CFG_SVH
`define SBAT_CFG_SVH
// =====================================================================
// Address geometry
`define SBAT_EA_W 64
`define SBAT_PAGE_SHIFT 12
`define SBAT_SEG_SHIFT 28
`define SBAT_BLK_SHIFT 17
`define SBAT_BLK_MASK_W 11
`define SBAT_VA_WIDE_W 80
`define SBAT_VA_NARROW_W 52
`define SBAT_VSID_W 52
`define SBAT_VSID_NARROW_W 24
`define SBAT_VPN_W 68
`define SBAT_PPN_W 52
`define SBAT_NARROW_PA_W 32
`define SBAT_SEG_ENTRIES 16
`define SBAT_BLK_ENTRIES 4
`define SBAT_TLB_ENTRIES 4
`define SBAT_ATTR_W 8
// =====================================================================
// Field positions
`define SBAT_TBL_VALID_BIT 63
`define SBAT_SEG_VALID_BIT 63
`define SBAT_BLK_LEN_LO 2
`define SBAT_BLK_VS_BIT 1
`define SBAT_BLK_VP_BIT 0
`define SBAT_EXC_WIDTH_BIT 2
// =====================================================================
// Options and reset values
`define SBAT_TBL_VALID_IMPL 1'b1
`define SBAT_EXC_WIDTH_IMPL 1'b1
`define SBAT_RST_WORD 64'h0000_0000_0000_0000
`define SBAT_RST_BIT 1'b0
`endif

// ### hdl/sbat_pkg.sv
// Types shared by the translation front end.
// Assumes sbat_cfg.svh is on the include path.
`include "sbat_cfg.svh"
package sbat_pkg;
    // =================================================================
    // Sequencer states and access kinds
    typedef enum logic [1:0] {
        SBAT_IDLE = 2'b00,
        SBAT_LOOKUP = 2'b01
    } sbat_state_e;
    typedef enum logic [1:0] {
        SBAT_FETCH = 2'b00,
        SBAT_LDST = 2'b01,
        SBAT_CACHE = 2'b10,
        SBAT_EXTCTL = 2'b11
    } sbat_kind_e;
    typedef logic [`SBAT_EA_W-1:0] sbat_word_t;
endpackage

// ### hdl/sbat_seg_mem.sv
// Sixteen-entry segment cache storage with a registered read port.
// Assumes one clock; a write and a read of one entry return old data.
`timescale 1ns/1ps
`default_nettype none
`include "sbat_cfg.svh"
module sbat_seg_mem (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire sbat_pkg::sbat_word_t wdata_i,
    input wire logic [3:0] raddr_i,
    output sbat_pkg::sbat_word_t rdata_o
);
    import sbat_pkg::*;
    typedef struct packed {
        logic [`SBAT_SEG_ENTRIES-1:0][`SBAT_EA_W-1:0] mem;
        logic [`SBAT_EA_W-1:0] rdata;
    } sbat_mem_s;
    sbat_mem_s s_q;
    sbat_mem_s s_d;

    // =================================================================
    // Storage
    // Entries clear at reset so no stale valid bit survives a restart.
    always_comb begin
        s_d = s_q;
        s_d.rdata = s_q.mem[raddr_i];
        if (we_i) begin
            s_d.mem[waddr_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
endmodule
`default_nettype wire

// ### hdl/sbat_top.sv
// Segment, block and page address translation front end.
// Assumes the core holds each request stable while ready is low.
`timescale 1ns/1ps
`default_nettype none
`include "sbat_cfg.svh"
module sbat_top (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire sbat_pkg::sbat_word_t req_ea_i,
    input wire sbat_pkg::sbat_kind_e req_kind_i,
    input wire logic req_store_i,
    input wire logic req_user_i,
    input wire logic inst_xlate_i,
    input wire logic data_xlate_i,
    input wire logic wide_mode_flag_i,
    input wire sbat_pkg::sbat_word_t segment_table_base_reg_i,
    input wire logic exception_width_select_i,
    input wire logic exc_entry_i,
    output logic exc_wide_o,
    output logic bridge_active_o,
    input wire logic seg_wr_i,
    input wire logic [3:0] seg_wr_idx_i,
    input wire sbat_pkg::sbat_word_t seg_wr_data_i,
    input wire logic spr_wr_i,
    input wire logic [2:0] spr_wr_sel_i,
    input wire sbat_pkg::sbat_word_t spr_wr_data_i,
    input wire logic spr_user_i,
    output logic spr_err_o,
    input wire logic tlb_wr_i,
    input wire logic [1:0] tlb_wr_idx_i,
    input wire logic [`SBAT_VPN_W-1:0] tlb_wr_vpn_i,
    input wire logic [`SBAT_PPN_W-1:0] tlb_wr_ppn_i,
    input wire logic [`SBAT_ATTR_W-1:0] tlb_wr_attr_i,
    output logic rsp_valid_o,
    output sbat_pkg::sbat_word_t rsp_pa_o,
    output logic [`SBAT_ATTR_W-1:0] rsp_attr_o,
    output logic rsp_block_o,
    output logic rsp_store_o,
    output logic rsp_fault_o
);
    import sbat_pkg::*;
    localparam int BW = `SBAT_EA_W - `SBAT_BLK_SHIFT;
    typedef struct packed {
        sbat_state_e st;
        logic ready;
        logic [`SBAT_EA_W-1:0] ea;
        logic user;
        logic store;
        logic xlate;
        logic wide;
        logic [`SBAT_BLK_ENTRIES-1:0][`SBAT_EA_W-1:0] blk_up;
        logic [`SBAT_BLK_ENTRIES-1:0][`SBAT_EA_W-1:0] blk_lo;
        logic [`SBAT_TLB_ENTRIES-1:0] tlb_v;
        logic [`SBAT_TLB_ENTRIES-1:0][`SBAT_VPN_W-1:0] tlb_vpn;
        logic [`SBAT_TLB_ENTRIES-1:0][`SBAT_PPN_W-1:0] tlb_ppn;
        logic [`SBAT_TLB_ENTRIES-1:0][`SBAT_ATTR_W-1:0] tlb_attr;
        logic rsp_valid;
        logic [`SBAT_EA_W-1:0] pa;
        logic [`SBAT_ATTR_W-1:0] attr;
        logic block;
        logic fault;
        logic spr_err;
        logic exc_wide;
        logic bridge;
    } sbat_top_s;
    sbat_top_s s_q, s_d;
    sbat_word_t seg_rd;
    logic tbl_valid, bridge;
    // =================================================================
    // Helpers
    // Block length mask widened to the block number width.
    function automatic logic [BW-1:0] blk_mask(input logic [63:0] up);
        blk_mask = {{(BW-`SBAT_BLK_MASK_W){1'b0}},
            up[`SBAT_BLK_LEN_LO+`SBAT_BLK_MASK_W-1:`SBAT_BLK_LEN_LO]};
    endfunction
    function automatic logic blk_hit(input logic [63:0] up,
        input logic [63:0] ea, input logic user);
        logic [BW-1:0] m;
        m = blk_mask(up);
        blk_hit = ((ea[63:`SBAT_BLK_SHIFT] & ~m) ==
            (up[63:`SBAT_BLK_SHIFT] & ~m)) &&
            (user ? up[`SBAT_BLK_VP_BIT] : up[`SBAT_BLK_VS_BIT]);
    endfunction
    // =================================================================
    // Mode decode
    // An unimplemented valid flag reads as set, so the bridge stays off.
    assign tbl_valid = `SBAT_TBL_VALID_IMPL ?
        segment_table_base_reg_i[`SBAT_TBL_VALID_BIT] : 1'b1;
    assign bridge = !tbl_valid && !wide_mode_flag_i;
    sbat_seg_mem u_seg_mem (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .we_i(seg_wr_i && bridge),
        .waddr_i(seg_wr_idx_i),
        .wdata_i(seg_wr_data_i),
        .raddr_i(req_ea_i[`SBAT_SEG_SHIFT+3:`SBAT_SEG_SHIFT]),
        .rdata_o(seg_rd)
    );
    // =================================================================
    // Next state
    // One request at a time: segment read in the accept cycle, match
    // in the lookup cycle. This costs a cycle but keeps paths short.
    always_comb begin
        logic [`SBAT_VPN_W-1:0] vpn;
        logic seg_ok, bhit, phit;
        logic [BW-1:0] m;
        vpn = '0;
        {seg_ok, bhit, phit} = 3'b000;
        m = '0;
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.spr_err = 1'b0;
        s_d.bridge = bridge;
        if (exc_entry_i) begin
            s_d.exc_wide = `SBAT_EXC_WIDTH_IMPL ?
                exception_width_select_i : 1'b1;
        end
        if (spr_wr_i) begin
            if (spr_user_i) begin
                s_d.spr_err = 1'b1;
            end else if (spr_wr_sel_i[0]) begin
                s_d.blk_lo[spr_wr_sel_i[2:1]] = spr_wr_data_i;
            end else begin
                s_d.blk_up[spr_wr_sel_i[2:1]] = spr_wr_data_i;
            end
        end
        if (tlb_wr_i) begin
            s_d.tlb_v[tlb_wr_idx_i] = 1'b1;
            s_d.tlb_vpn[tlb_wr_idx_i] = tlb_wr_vpn_i;
            s_d.tlb_ppn[tlb_wr_idx_i] = tlb_wr_ppn_i;
            s_d.tlb_attr[tlb_wr_idx_i] = tlb_wr_attr_i;
        end
        case (s_q.st)
            SBAT_IDLE: begin
                if (req_valid_i) begin
                    s_d.ea = req_ea_i;
                    if (!wide_mode_flag_i) begin
                        s_d.ea[63:32] = 32'h0;
                    end
                    s_d.user = req_user_i;
                    s_d.store = req_store_i;
                    s_d.xlate = (req_kind_i == SBAT_FETCH) ?
                        inst_xlate_i : data_xlate_i;
                    s_d.wide = wide_mode_flag_i;
                    s_d.ready = 1'b0;
                    s_d.st = SBAT_LOOKUP;
                end
            end
            SBAT_LOOKUP: begin
                // Narrow VSID keeps 24 bits, so the VA is 52 bits wide.
                if (s_q.wide) begin
                    vpn = {seg_rd[`SBAT_VSID_W-1:0],
                        s_q.ea[27:`SBAT_PAGE_SHIFT]};
                end else begin
                    vpn = {28'h0, seg_rd[`SBAT_VSID_NARROW_W-1:0],
                        s_q.ea[27:`SBAT_PAGE_SHIFT]};
                end
                seg_ok = seg_rd[`SBAT_SEG_VALID_BIT] && (bridge || tbl_valid)
                    && (s_q.ea[63:32] == 32'h0);
                s_d.pa = s_q.ea;
                s_d.attr = '0;
                s_d.block = 1'b0;
                s_d.fault = 1'b0;
                for (int i = 0; i < `SBAT_TLB_ENTRIES; i++) begin
                    if (!phit && seg_ok && s_q.tlb_v[i] &&
                        s_q.tlb_vpn[i] == vpn) begin
                        phit = 1'b1;
                        s_d.pa = {s_q.tlb_ppn[i],
                            s_q.ea[`SBAT_PAGE_SHIFT-1:0]};
                        s_d.attr = s_q.tlb_attr[i];
                    end
                end
                // Block entries win over pages; lowest index first.
                for (int i = `SBAT_BLK_ENTRIES - 1; i >= 0; i--) begin
                    if (blk_hit(s_q.blk_up[i], s_q.ea, s_q.user)) begin
                        bhit = 1'b1;
                        m = blk_mask(s_q.blk_up[i]);
                        s_d.pa = {(s_q.blk_lo[i][63:`SBAT_BLK_SHIFT] & ~m) |
                            (s_q.ea[63:`SBAT_BLK_SHIFT] & m),
                            s_q.ea[`SBAT_BLK_SHIFT-1:0]};
                        s_d.attr = s_q.blk_lo[i][`SBAT_ATTR_W-1:0];
                    end
                end
                if (s_q.xlate) begin
                    s_d.block = bhit;
                    if (!bhit && !phit) begin
                        s_d.fault = 1'b1;
                        s_d.pa = '0;
                    end
                    if (!s_q.wide) begin
                        s_d.pa[63:`SBAT_NARROW_PA_W] = 32'h0;
                    end
                end else begin
                    s_d.pa = s_q.ea;
                end
                s_d.rsp_valid = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = SBAT_IDLE;
            end
            default: begin
                s_d.st = SBAT_IDLE;
                s_d.ready = 1'b1;
            end
        endcase
    end
    // =================================================================
    // State register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.ready <= 1'b1;
            s_q.exc_wide <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    assign req_ready_o = s_q.ready;
    assign rsp_valid_o = s_q.rsp_valid;
    assign rsp_pa_o = s_q.pa;
    assign rsp_attr_o = s_q.attr;
    assign rsp_block_o = s_q.block;
    assign rsp_store_o = s_q.store;
    assign rsp_fault_o = s_q.fault;
    assign spr_err_o = s_q.spr_err;
    assign exc_wide_o = s_q.exc_wide;
    assign bridge_active_o = s_q.bridge;
    // =================================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_real;
        rsp_valid_o && !s_q.xlate |-> rsp_pa_o == s_q.ea && !rsp_fault_o;
    endproperty
    a_real: assert property (p_real) else $error("real mode pa");
    property p_narrow;
        rsp_valid_o && !s_q.wide |-> rsp_pa_o[63:32] == 32'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("pa high");
    property p_pglow;
        rsp_valid_o && s_q.xlate && !rsp_fault_o && !rsp_block_o
            |-> rsp_pa_o[11:0] == s_q.ea[11:0];
    endproperty
    a_pglow: assert property (p_pglow) else $error("page offset");
    property p_blklow;
        rsp_valid_o && rsp_block_o |-> rsp_pa_o[16:0] == s_q.ea[16:0];
    endproperty
    a_blklow: assert property (p_blklow) else $error("blk offset");
    property p_lat;
        req_valid_i && req_ready_o |=> !req_ready_o ##1
            (rsp_valid_o && req_ready_o);
    endproperty
    a_lat: assert property (p_lat) else $error("late response");
    property p_bridge;
        ##1 bridge_active_o ==
            (!$past(wide_mode_flag_i) && !$past(tbl_valid));
    endproperty
    a_bridge: assert property (p_bridge) else $error("bridge flag");
    property p_spr;
        spr_wr_i && spr_user_i |=> spr_err_o;
    endproperty
    a_spr: assert property (p_spr) else $error("user write kept");
    property p_exc;
        exc_entry_i |=> exc_wide_o ==
            ($past(exception_width_select_i) || !`SBAT_EXC_WIDTH_IMPL);
    endproperty
    a_exc: assert property (p_exc) else $error("exc width");
    property p_fault;
        rsp_valid_o && rsp_fault_o |-> s_q.xlate && !rsp_block_o;
    endproperty
    a_fault: assert property (p_fault) else $error("stray fault");
    c_block: cover property (rsp_valid_o && rsp_block_o);
    c_page: cover property (rsp_valid_o && s_q.xlate && !rsp_block_o
        && !rsp_fault_o);
    c_fault: cover property (rsp_valid_o && rsp_fault_o);
    c_bridge: cover property (bridge_active_o && seg_wr_i);
endmodule
`default_nettype wire

// ### tb/sbat_core_model.sv
// Core-side requester model for the translation front end.
// Assumes the bench calls translate() between its own register writes.
`timescale 1ns/1ps
`default_nettype none
module sbat_core_model (
    input wire logic clk_i,
    input wire logic ready_i,
    input wire logic rsp_valid_i,
    output logic req_valid_o,
    output sbat_pkg::sbat_word_t req_ea_o,
    output sbat_pkg::sbat_kind_e req_kind_o,
    output logic req_store_o,
    output logic req_user_o
);
    import sbat_pkg::*;
    // =================================================================
    // Idle values
    initial begin
        req_valid_o = 1'b0;
        req_ea_o = 64'h0;
        req_kind_o = SBAT_FETCH;
        req_store_o = 1'b0;
        req_user_o = 1'b0;
    end
    // =================================================================
    // One request; ok is low if the answer breaks the handshake timing.
    // Released fields show inverted values so stale data cannot match.
    task automatic translate(input sbat_word_t ea, input sbat_kind_e kind,
        input logic store, input logic user, output logic ok);
        int n;
        n = 0;
        @(negedge clk_i);
        req_valid_o = 1'b1;
        req_ea_o = ea;
        req_kind_o = kind;
        req_store_o = store;
        req_user_o = user;
        while (ready_i !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        req_valid_o = 1'b0;
        req_ea_o = ~ea;
        req_kind_o = sbat_kind_e'(~kind);
        req_store_o = ~store;
        req_user_o = ~user;
        ok = (ready_i === 1'b0) && (n < 8);
        n = 0;
        while (rsp_valid_i !== 1'b1 && n < 2) begin
            @(negedge clk_i);
            n++;
        end
        ok = ok && (rsp_valid_i === 1'b1);
        @(negedge clk_i);
        ok = ok && (rsp_valid_i === 1'b0);
    endtask
endmodule
`default_nettype wire

// ### tb/sbat_testbench.sv
// Self-checking bench for the translation front end.
// Assumes the package, the design and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sbat_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    err_total++; \
    $display("unexpected at %0t: compare %0d", $time, compares); end end
module testbench;
    import sbat_pkg::*;
    logic clk, reset, req_valid, req_ready, req_store, req_user, ok;
    logic inst_x, data_x, wide, exc_sel, exc_entry, exc_wide, bridge;
    logic seg_wr, spr_wr, spr_user, spr_err, tlb_wr, rsp_valid;
    logic rsp_block, rsp_store, rsp_fault;
    sbat_word_t req_ea, tbase, seg_data, spr_data, rsp_pa;
    sbat_kind_e req_kind;
    logic [3:0] seg_idx;
    logic [2:0] spr_sel;
    logic [1:0] tlb_idx;
    logic [`SBAT_VPN_W-1:0] tlb_vpn;
    logic [`SBAT_PPN_W-1:0] tlb_ppn;
    logic [`SBAT_ATTR_W-1:0] tlb_attr, rsp_attr;
    int err_total, compares;
    sbat_top sbat_top_inst (.clk_i(clk), .reset_i(reset),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_ea_i(req_ea),
        .req_kind_i(req_kind), .req_store_i(req_store), .req_user_i(req_user),
        .inst_xlate_i(inst_x), .data_xlate_i(data_x), .wide_mode_flag_i(wide),
        .segment_table_base_reg_i(tbase), .exception_width_select_i(exc_sel),
        .exc_entry_i(exc_entry), .exc_wide_o(exc_wide),
        .bridge_active_o(bridge), .seg_wr_i(seg_wr), .seg_wr_idx_i(seg_idx),
        .seg_wr_data_i(seg_data), .spr_wr_i(spr_wr), .spr_wr_sel_i(spr_sel),
        .spr_wr_data_i(spr_data), .spr_user_i(spr_user), .spr_err_o(spr_err),
        .tlb_wr_i(tlb_wr), .tlb_wr_idx_i(tlb_idx), .tlb_wr_vpn_i(tlb_vpn),
        .tlb_wr_ppn_i(tlb_ppn), .tlb_wr_attr_i(tlb_attr),
        .rsp_valid_o(rsp_valid), .rsp_pa_o(rsp_pa), .rsp_attr_o(rsp_attr),
        .rsp_block_o(rsp_block), .rsp_store_o(rsp_store),
        .rsp_fault_o(rsp_fault));
    sbat_core_model sbat_core_model_inst (.clk_i(clk), .ready_i(req_ready),
        .rsp_valid_i(rsp_valid), .req_valid_o(req_valid), .req_ea_o(req_ea),
        .req_kind_o(req_kind), .req_store_o(req_store),
        .req_user_o(req_user));
    // =================================================================
    // Clock, and a watchdog of 20000 cycles, well beyond the hundred or so needed.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
    // =================================================================
    // Shared drivers; every strobe lasts exactly one clock.
    task automatic xl(input sbat_word_t ea, input sbat_kind_e k,
        input logic st, input logic us);
        sbat_core_model_inst.translate(ea, k, st, us, ok);
        `CHK(ok, 1'b1)
        `CHK(rsp_store, st)
    endtask
    task automatic spr_put(input logic [2:0] s, input sbat_word_t d,
        input logic us);
        logic seen;
        @(negedge clk);
        {spr_wr, spr_sel, spr_data, spr_user} = {1'b1, s, d, us};
        @(negedge clk);
        spr_wr = 1'b0;
        seen = spr_err;
        @(negedge clk);
        `CHK(seen | spr_err, us)
    endtask
    task automatic seg_put(input logic [3:0] i, input sbat_word_t d);
        @(negedge clk);
        {seg_wr, seg_idx, seg_data} = {1'b1, i, d};
        @(negedge clk);
        seg_wr = 1'b0;
    endtask
    task automatic exc_pulse(input logic sel);
        @(negedge clk);
        {exc_entry, exc_sel} = {1'b1, sel};
        @(negedge clk);
        exc_entry = 1'b0;
        `CHK(exc_wide, sel)
    endtask
    // =================================================================
    // Scenarios.
    task automatic test_real();
        sbat_word_t ea;
        ea = 64'hfedc_ba98_7654_3210;
        {inst_x, data_x} = 2'b00;
        for (int k = 0; k < 4; k++) begin
            wide = 1'b1;
            xl(ea + k, sbat_kind_e'(k), k[0], 1'b0);
            `CHK(rsp_pa, ea + k)
            `CHK(rsp_fault, 1'b0)
            wide = 1'b0;
            xl(ea + k, sbat_kind_e'(k), k[1], 1'b1);
            `CHK(rsp_pa, {32'h0, ea[31:0] + 32'(k)})
        end
        $display("test real done");
    endtask
    task automatic test_block();
        sbat_word_t ea, lo;
        ea = 64'h1234_5678_9abc_def0;
        lo = 64'hcafe_0000_0000_00a5;
        {inst_x, data_x, wide} = 3'b111;
        xl(ea, SBAT_FETCH, 1'b0, 1'b0);
        `CHK(rsp_fault, 1'b1)
        `CHK(rsp_pa, 64'h0)
        spr_put(3'b010, {ea[63:28], 15'h0, 11'h7ff, 2'b10}, 1'b0);
        spr_put(3'b011, lo, 1'b0);
        xl(ea, SBAT_LDST, 1'b0, 1'b0);
        `CHK(rsp_pa, {lo[63:28], ea[27:0]})
        `CHK(rsp_attr, 8'ha5)
        `CHK(rsp_block, 1'b1)
        spr_put(3'b011, 64'h0, 1'b1);
        xl(ea, SBAT_CACHE, 1'b1, 1'b0);
        `CHK(rsp_pa, {lo[63:28], ea[27:0]})
        xl(ea, SBAT_EXTCTL, 1'b0, 1'b1);
        `CHK(rsp_fault, 1'b1)
        $display("test block done");
    endtask
    task automatic test_bridge();
        sbat_word_t sd;
        sd = {1'b1, 39'h0, 24'habcdef};
        {tbase, wide, data_x} = {64'h0, 1'b1, 1'b1};
        seg_put(4'h5, sd);
        wide = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(bridge, 1'b1)
        seg_put(4'h3, sd);
        @(negedge clk);
        {tlb_wr, tlb_idx, tlb_ppn, tlb_attr} = {3'b101, 52'h1_2345, 8'h5a};
        tlb_vpn = {28'h0, 24'habcdef, 16'h2345};
        @(negedge clk);
        tlb_wr = 1'b0;
        xl(64'hffff_ffff_3234_5678, SBAT_LDST, 1'b0, 1'b1);
        `CHK(rsp_pa, 64'h0000_0000_1234_5678)
        `CHK(rsp_attr, 8'h5a)
        `CHK(rsp_fault, 1'b0)
        xl(64'h0000_0000_5234_5678, SBAT_LDST, 1'b0, 1'b1);
        `CHK(rsp_fault, 1'b1)
        tbase = 64'h8000_0000_0000_0000;
        repeat (2) @(negedge clk);
        `CHK(bridge, 1'b0)
        wide = 1'b1;
        // Wide page path: valid table base lets the cached segment serve.
        xl(64'h0000_0000_3234_5678, SBAT_FETCH, 1'b0, 1'b0);
        `CHK(rsp_pa, 64'h0000_0000_1234_5678)
        `CHK(rsp_block, 1'b0)
        tbase = 64'h0;
        xl(64'h0000_0000_3234_5678, SBAT_FETCH, 1'b0, 1'b0);
        `CHK(rsp_fault, 1'b1)
        tbase = 64'h8000_0000_0000_0000;
        $display("test bridge done");
    endtask
    // =================================================================
    // Verdict and main sequence.
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        {err_total, compares} = 0;
        {reset, inst_x, data_x, wide, exc_sel, exc_entry} = 6'b100110;
        {seg_wr, spr_wr, spr_user, tlb_wr} = 4'h0;
        {seg_idx, spr_sel, tlb_idx} = 9'h0;
        {seg_data, spr_data} = 128'h0;
        {tlb_vpn, tlb_ppn, tlb_attr} = 128'h0;
        tbase = 64'h8000_0000_0000_0000;
        repeat (6) @(negedge clk);
        `CHK({req_ready, rsp_valid, exc_wide, spr_err}, 4'b1010)
        reset = 1'b0;
        test_real();
        test_block();
        test_bridge();
        exc_pulse(1'b0);
        exc_pulse(1'b1);
        $display("test exception width done");
        complete_run();
    end
endmodule
`default_nettype wire
